// File: logic/ppo_port_b.v
// port B pin override: registers, spi/timer/pin-change mapping, pads
// assumes pad inputs are asynchronous; peripherals run on clk
//
// How it works
// - pull-up override enable makes pull-up follow override value.
// - without override, pull-up on only when direction, latch, disable are 010.
// - direction override enable makes driver enable equal override value.
// - without direction override, driver enable comes from direction bit.
// - value override, driver on: pad level equals override value.
// - no value override, driver on: pad level equals latch bit.
// - toggle override enable inverts that pin's latch bit.
// - no input override: input enabled normally, clamped in deep sleep.
// - input override enable makes input enable equal override value.
// - alternate input taken before the port synchroniser; consumer syncs.
// - write strobes shared per port; sleep and disable shared; overrides per pin.
// - spi slave forces slave-select to input; active only while low.
// - spi master leaves slave-select direction to its direction bit.
// - forced spi input pins keep pull-up under latch bit control.
// - serial clock forced input as slave, direction bit as master.
// - miso forced input as master, direction bit as slave.
// - mosi forced input as slave, direction bit as master.
// - each port B pin n is pin-change source n.
// - direction one drives latch bit; direction zero makes an input.
// - writing one to an input-register bit inverts the latch bit.
`timescale 1ns/100ps
`include "ppo_defines.vh"

module ppo_port_b (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       clk_en,
	input  wire       wr_dir,
	input  wire       wr_latch,
	input  wire       wr_toggle,
	input  wire [7:0] wr_data,
	input  wire       global_pullup_disable,
	input  wire       sleep_clamp,
	input  wire [7:0] pad_in,
	input  wire       spi_en,
	input  wire       spi_master,
	input  wire       spi_sck_out,
	input  wire       spi_slave_out,
	input  wire       spi_master_out,
	input  wire [7:0] pin_change_en,
	input  wire       timer3_mod_en,
	input  wire       timer3_modulator_out,
	input  wire [7:0] toggle_override_en,
	output reg  [7:0] pin_direction_bit,
	output reg  [7:0] pin_output_latch_bit,
	output reg  [7:0] pin_input_bit,
	output wire [7:0] pad_out,
	output wire [7:0] pad_oe,
	output wire [7:0] pad_pullup,
	output wire [7:0] pad_input_en,
	output wire [7:0] alt_digital_in,
	output wire       spi_slave_selected,
	output wire       spi_sck_in,
	output wire       spi_miso_in,
	output wire       spi_mosi_in,
	output wire       shared_timer_clock_in,
	output wire       timer3_capture_in
);

	// ****************************************
	// per-pin override sources
	// ****************************************
	wire       slave_mode;
	wire       master_mode;
	wire [7:0] pu_oe;
	wire [7:0] pu_ov;
	wire [7:0] dd_oe;
	wire [7:0] pv_oe;
	wire [7:0] pv_ov;
	wire [7:0] gated_in;
	wire [7:0] nonsleep_in;
	reg  [7:0] sync1_q;

	assign slave_mode  = spi_en & ~spi_master;
	assign master_mode = spi_en & spi_master;

	// forced inputs keep latch pull-up
	// the disable bit still wins, so a forced input never pulls up under it
	assign pu_ov = pin_output_latch_bit & {8{~global_pullup_disable}};

	// ****************************************
	// pin 7: spi slave select
	// ****************************************
	// overrides are separate per pin
	// slave select forced input as slave
	assign dd_oe[`PPO_BIT_SS] = slave_mode;
	assign pu_oe[`PPO_BIT_SS] = slave_mode;
	// never driven by the spi, so no value override
	assign pv_oe[`PPO_BIT_SS] = 1'b0;
	assign pv_ov[`PPO_BIT_SS] = 1'b0;

	// ****************************************
	// pin 6: pin-change source only
	// ****************************************
	// plain port pin: direction, latch and pull-up stay with software
	assign dd_oe[`PPO_BIT_PC6] = 1'b0;
	assign pu_oe[`PPO_BIT_PC6] = 1'b0;
	assign pv_oe[`PPO_BIT_PC6] = 1'b0;
	assign pv_ov[`PPO_BIT_PC6] = 1'b0;

	// ****************************************
	// pin 5: spi serial clock
	// ****************************************
	// serial clock forced input as slave
	assign dd_oe[`PPO_BIT_SCK] = slave_mode;
	assign pu_oe[`PPO_BIT_SCK] = slave_mode;
	// master drives the clock when its direction bit allows
	assign pv_oe[`PPO_BIT_SCK] = master_mode;
	assign pv_ov[`PPO_BIT_SCK] = spi_sck_out;

	// ****************************************
	// pin 4: spi master in, slave out
	// ****************************************
	// miso forced input as master
	assign dd_oe[`PPO_BIT_MISO] = master_mode;
	assign pu_oe[`PPO_BIT_MISO] = master_mode;
	// a slave answers here; software must set the direction bit
	assign pv_oe[`PPO_BIT_MISO] = slave_mode;
	assign pv_ov[`PPO_BIT_MISO] = spi_slave_out;

	// ****************************************
	// pin 3: spi master out, slave in
	// ****************************************
	// mosi forced input as slave
	assign dd_oe[`PPO_BIT_MOSI] = slave_mode;
	assign pu_oe[`PPO_BIT_MOSI] = slave_mode;
	// master data goes out only where the direction bit allows
	assign pv_oe[`PPO_BIT_MOSI] = master_mode;
	assign pv_ov[`PPO_BIT_MOSI] = spi_master_out;

	// ****************************************
	// pin 2: shared timer clock input
	// ****************************************
	// input only; software keeps the direction bit low for the timers
	assign dd_oe[`PPO_BIT_TCLK] = 1'b0;
	assign pu_oe[`PPO_BIT_TCLK] = 1'b0;
	assign pv_oe[`PPO_BIT_TCLK] = 1'b0;
	assign pv_ov[`PPO_BIT_TCLK] = 1'b0;

	// ****************************************
	// pin 1: timer3 modulator output
	// ****************************************
	// modulator takes the pad value; direction bit must be one
	assign dd_oe[`PPO_BIT_T3MOD] = 1'b0;
	assign pu_oe[`PPO_BIT_T3MOD] = 1'b0;
	assign pv_oe[`PPO_BIT_T3MOD] = timer3_mod_en;
	assign pv_ov[`PPO_BIT_T3MOD] = timer3_modulator_out;

	// ****************************************
	// pin 0: timer3 capture input
	// ****************************************
	// input only; the capture unit syncs it on its own
	assign dd_oe[`PPO_BIT_T3CAP] = 1'b0;
	assign pu_oe[`PPO_BIT_T3CAP] = 1'b0;
	assign pv_oe[`PPO_BIT_T3CAP] = 1'b0;
	assign pv_ov[`PPO_BIT_T3CAP] = 1'b0;

	// ****************************************
	// pin cells
	// ****************************************
	// combinational pad controls
	genvar gi;
	generate
		for (gi = 0; gi < `PPO_NPINS; gi = gi + 1) begin : g_pin
			ppo_pin_cell u_cell (
				.dir_bit              (pin_direction_bit[gi]),
				.latch_bit            (pin_output_latch_bit[gi]),
				.global_pullup_disable(global_pullup_disable),
				.sleep_clamp          (sleep_clamp),
				.pullup_override_en   (pu_oe[gi]),
				.pullup_override_val  (pu_ov[gi]),
				.dir_override_en      (dd_oe[gi]),
				.dir_override_val     (1'b0),
				.value_override_en    (pv_oe[gi]),
				.value_override_val   (pv_ov[gi]),
				.input_en_override_en (pin_change_en[gi]),
				.input_en_override_val(1'b1),
				.pullup_on            (pad_pullup[gi]),
				.drive_en             (pad_oe[gi]),
				.drive_val            (pad_out[gi]),
				.input_en             (pad_input_en[gi])
			);
		end
	endgenerate

	// ****************************************
	// alternate inputs
	// ****************************************
	// tapped before the synchroniser
	assign gated_in       = pad_in & pad_input_en;
	assign alt_digital_in = gated_in;
	assign nonsleep_in    = gated_in;

	// pin n is pin-change source n
	assign spi_slave_selected = slave_mode & ~gated_in[`PPO_BIT_SS];
	assign spi_sck_in         = gated_in[`PPO_BIT_SCK];
	assign spi_miso_in        = gated_in[`PPO_BIT_MISO];
	assign spi_mosi_in        = gated_in[`PPO_BIT_MOSI];
	assign shared_timer_clock_in = gated_in[`PPO_BIT_TCLK];
	assign timer3_capture_in     = gated_in[`PPO_BIT_T3CAP];

	// ****************************************
	// port registers
	// ****************************************
	// two flops guard the readback against pad metastability
	always @(posedge clk) begin
		if (!rst_n) begin
			sync1_q       <= `PPO_RST_BYTE;
			pin_input_bit <= `PPO_RST_BYTE;
		end else if (clk_en) begin
			sync1_q       <= nonsleep_in;
			pin_input_bit <= sync1_q;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			pin_direction_bit <= `PPO_RST_BYTE;
		end else if (clk_en && wr_dir) begin
			pin_direction_bit <= wr_data;
		end
	end

	// next latch value: plain write first, then software and hardware
	// toggles; a toggle in the same cycle as a write flips the new value
	function [7:0] latch_next;
		input [7:0] cur;
		input       load;
		input       flip;
		input [7:0] data;
		input [7:0] hw_flip;
		begin
			latch_next = (load ? data : cur) ^
				(flip ? data : `PPO_RST_BYTE) ^ hw_flip;
		end
	endfunction

	always @(posedge clk) begin
		if (!rst_n) begin
			pin_output_latch_bit <= `PPO_RST_BYTE;
		end else if (clk_en) begin
			pin_output_latch_bit <= latch_next(pin_output_latch_bit,
				wr_latch, wr_toggle, wr_data, toggle_override_en);
		end
	end

endmodule // ppo_port_b

// File: logic/ppo_defines.vh
// constants for the port B pin override block
// assumes plain verilog-2005 and inclusion by bare name
`ifndef PPO_DEFINES_VH
`define PPO_DEFINES_VH

`define PPO_NPINS         8
`define PPO_PU_PLAIN      3'b010
`define PPO_BIT_SS        7
`define PPO_BIT_PC6       6
`define PPO_BIT_SCK       5
`define PPO_BIT_MISO      4
`define PPO_BIT_MOSI      3
`define PPO_BIT_TCLK      2
`define PPO_BIT_T3MOD     1
`define PPO_BIT_T3CAP     0
`define PPO_RST_BYTE      8'h00

`endif

// File: logic/ppo_pin_cell.v
// one port pin: combinational override of pull-up, driver, value, input
// assumes register bits and overrides arrive on the module clock
`timescale 1ns/100ps

module ppo_pin_cell (
	input  wire dir_bit,
	input  wire latch_bit,
	input  wire global_pullup_disable,
	input  wire sleep_clamp,
	input  wire pullup_override_en,
	input  wire pullup_override_val,
	input  wire dir_override_en,
	input  wire dir_override_val,
	input  wire value_override_en,
	input  wire value_override_val,
	input  wire input_en_override_en,
	input  wire input_en_override_val,
	output wire pullup_on,
	output wire drive_en,
	output wire drive_val,
	output wire input_en
);

	assign pullup_on = pullup_override_en ? pullup_override_val :
		({dir_bit, latch_bit, global_pullup_disable} == `PPO_PU_PLAIN);

	assign drive_en = dir_override_en ? dir_override_val : dir_bit;

	assign drive_val = value_override_en ? value_override_val : latch_bit;

	assign input_en = input_en_override_en ? input_en_override_val :
		~sleep_clamp;

endmodule // ppo_pin_cell

// File: verification/ppo_port_b_sva.sv
// checker for the port B override block
// assumes it is bound to ppo_port_b and sees only its ports
`timescale 1ns/100ps
module ppo_port_b_chk (
	input wire       clk, rst_n, clk_en, wr_dir, wr_latch, wr_toggle,
	input wire       global_pullup_disable, sleep_clamp, spi_en, spi_master,
	input wire       spi_sck_out, timer3_mod_en,
	input wire [7:0] wr_data, pin_change_en, toggle_override_en,
	input wire [7:0] pin_direction_bit, pin_output_latch_bit, pin_input_bit,
	input wire [7:0] pad_out, pad_oe, pad_pullup, pad_input_en, alt_digital_in
);
	wire [7:0] dir = pin_direction_bit;
	wire [7:0] lat = pin_output_latch_bit;
	wire slave = spi_en && !spi_master;
	wire master = spi_en && spi_master;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// the synchroniser needs two loaded edges before it shows the pad
	sequence in_steady; (clk_en && $stable(alt_digital_in))[*3]; endsequence
	pu_plain_a: assert property (!spi_en |->
		pad_pullup == (~dir & lat & {8{!global_pullup_disable}}))
		else $error("plain pull-up wrong");
	pu_forced_a: assert property (slave |->
		pad_pullup[7] == (lat[7] && !global_pullup_disable))
		else $error("forced pull-up wrong");
	oe_plain_a: assert property (!spi_en |-> pad_oe == dir)
		else $error("driver enable wrong");
	slave_in_a: assert property (slave |-> pad_oe[7:3] == (dir[7:3] & 5'h0a))
		else $error("slave directions wrong");
	master_in_a: assert property (master |-> pad_oe[7:3] == (dir[7:3] & 5'h1d))
		else $error("master directions wrong");
	sck_drive_a: assert property (master && pad_oe[5] |->
		pad_out[5] == spi_sck_out) else $error("clock pad value wrong");
	latch_drive_a: assert property (!spi_en && !timer3_mod_en |->
		(pad_out & pad_oe) == (lat & pad_oe)) else $error("pad value wrong");
	input_en_a: assert property (pad_input_en ==
		(pin_change_en | {8{!sleep_clamp}})) else $error("input enable wrong");
	dir_load_a: assert property (clk_en && wr_dir |=> dir == $past(wr_data))
		else $error("direction load wrong");
	toggle_ov_a: assert property (clk_en && !wr_latch && !wr_toggle |=>
		lat == ($past(lat) ^ $past(toggle_override_en)))
		else $error("toggle override wrong");
	sync_in_a: assert property (in_steady |-> pin_input_bit == alt_digital_in)
		else $error("input register wrong");
endmodule // ppo_port_b_chk
bind ppo_port_b ppo_port_b_chk ppo_port_b_chk_i (.*);

// File: verification/ppo_pad_partner.sv
// pads and outside world around port B
// assumes drive, enable and pull-up come straight from the block
`timescale 1ns/100ps
module ppo_pad_partner (
	input wire [7:0]  pad_out, pad_oe, pad_pullup, ext_drv, ext_lvl,
	output wire [7:0] pad_in
);
	// driven pad wins; a floating pad shows the inverse value
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_lvl)
		| (~pad_oe & ~ext_drv & pad_pullup)
		| (~pad_oe & ~ext_drv & ~pad_pullup & ~pad_out);
endmodule // ppo_pad_partner

// File: verification/port_pin_alternate_override_bench.sv
// self-checking bench for the port B override block
// assumes the checker is bound in and the pad model closes the pins
`timescale 1ns/100ps
module port_pin_alternate_override_bench;
	reg clk = 0, rst_n = 0, wr_dir = 0, wr_latch = 0, wr_toggle = 0;
	reg pu_off = 0, sleep_clamp = 0, spi_en = 0, spi_master = 0, sck_o = 0;
	reg ce = 1, tm_en = 0, tm_o = 0;
	reg [7:0] wr_data = 0, pce = 0, toe = 0, ext_drv = 0, ext_lvl = 0;
	wire [7:0] dir, lat, pin_in, pad_out, pad_oe, pad_pu, pad_ie, alt, pad_in;
	wire       sel;
	wire       sck_in, miso_in, mosi_in, tclk, tcap;
	integer    miscompares = 0, compares = 0;
	always #20 clk = ~clk;
	ppo_port_b ppo_port_b_i (.clk(clk), .rst_n(rst_n), .clk_en(ce),
		.wr_dir(wr_dir), .wr_latch(wr_latch), .wr_toggle(wr_toggle),
		.wr_data(wr_data), .global_pullup_disable(pu_off),
		.sleep_clamp(sleep_clamp), .pad_in(pad_in), .spi_en(spi_en),
		.spi_master(spi_master), .spi_sck_out(sck_o), .spi_slave_out(sck_o),
		.spi_master_out(~sck_o), .pin_change_en(pce), .timer3_mod_en(tm_en),
		.timer3_modulator_out(tm_o), .toggle_override_en(toe),
		.pin_direction_bit(dir), .pin_output_latch_bit(lat),
		.pin_input_bit(pin_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pu), .pad_input_en(pad_ie), .alt_digital_in(alt),
		.spi_slave_selected(sel), .spi_sck_in(sck_in),
		.spi_miso_in(miso_in), .spi_mosi_in(mosi_in),
		.shared_timer_clock_in(tclk), .timer3_capture_in(tcap));
	ppo_pad_partner ppo_pad_partner_i (.pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pu), .ext_drv(ext_drv), .ext_lvl(ext_lvl),
		.pad_in(pad_in));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	// k: 0 direction, 1 latch, 2 toggle
	task wr(input [1:0] k, input [7:0] d);
		begin
			@(posedge clk);
			wr_dir <= k == 0;
			wr_latch <= k == 1;
			wr_toggle <= k == 2;
			wr_data <= d;
			@(posedge clk);
			{wr_dir, wr_latch, wr_toggle} <= 3'h0;
			#1;
		end
	endtask
	task t_plain;
		begin
			wr(0, 8'h0f);
			wr(1, 8'h35);
			chk(pad_oe, 8'h0f);
			chk(pad_pu, 8'h30);
			chk(pad_out & pad_oe, 8'h05);
			repeat (2) @(posedge clk);
			#1 chk(pin_in & 8'h0f, 8'h05);
			@(posedge clk) pu_off <= 1;
			#1 chk(pad_pu, 8'h00);
			wr(2, 8'hff);
			chk(lat, 8'hca);
			@(posedge clk) toe <= 8'h81;
			@(posedge clk) toe <= 8'h00;
			#1 chk(lat, 8'h4b);
			$display("plain pins done");
		end
	endtask
	task t_spi;
		begin
			wr(0, 8'hff);
			@(posedge clk) spi_en <= 1;
			ext_drv <= 8'h80;
			#1 chk(pad_oe, 8'h57);
			chk({7'h0, sel}, 8'h01);
			@(posedge clk) spi_master <= 1;
			sck_o <= 1;
			#1 chk(pad_oe, 8'hef);
			chk({7'h0, pad_out[5]}, 8'h01);
			chk({7'h0, miso_in}, 8'h01);
			chk({6'h0, sck_in, mosi_in}, 8'h02);
			@(posedge clk) spi_en <= 0;
			$display("spi pins done");
		end
	endtask
	task t_input;
		begin
			@(posedge clk) sleep_clamp <= 1;
			pce <= 8'h01;
			#1 chk(pad_ie, 8'h01);
			chk(alt, 8'h01);
			$display("input enable done");
		end
	endtask
	task t_timer;
		begin
			wr(0, 8'h02);
			@(posedge clk) sleep_clamp <= 0;
			tm_en <= 1;
			ext_drv <= 8'h05;
			ext_lvl <= 8'h04;
			#1 chk({7'h0, pad_out[1]}, 8'h00);
			chk({6'h0, tclk, tcap}, 8'h02);
			chk(alt, 8'hb4);
			$display("timer pins done");
		end
	endtask
	task t_freeze;
		begin
			@(posedge clk) ce <= 0;
			wr_dir <= 1;
			wr_data <= 8'h55;
			@(posedge clk) wr_dir <= 0;
			ce <= 1;
			#1 chk(dir, 8'h02);
			$display("clock enable done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		#20000 miscompares = miscompares + 1;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		t_plain;
		t_spi;
		t_input;
		t_timer;
		t_freeze;
		tally_and_finish;
	end
endmodule // port_pin_alternate_override_bench
